/* File: common/cmac_params.svh */
// Constants for the configuration menu access controller
// ==========================================================
`ifndef CMAC_PARAMS_SVH
`define CMAC_PARAMS_SVH

// ==========================================================
// Register byte addresses
`define ADDR_STATUS    8'h00
`define ADDR_CODE      8'h04
`define ADDR_CONFIG    8'h08
`define ADDR_ZERO      8'h0C
`define ADDR_SPAN      8'h10
`define ADDR_NVM_IDX   8'h14
`define ADDR_NVM_DATA  8'h18
`define ADDR_SAVES     8'h1C

// ==========================================================
// Config register fields
`define CFG_MAP_LSB    0
`define CFG_STEP_LSB   2
`define CFG_RADIX_LSB  4
`define CFG_PCT_BIT    6
`define CFG_TARE_BIT   7

// ==========================================================
// Factory defaults
`define DEF_CODE       16'h0000
`define DEF_MAP        2'h0
`define DEF_STEP       2'h0
`define DEF_RADIX      2'h1
`define DEF_PCT        1'b1
`define DEF_TARE       1'b0
`define DEF_ZERO       16'h0000
`define DEF_SPAN       16'h03E8

// ==========================================================
// Stored word slots
`define NVM_CODE       3'h0
`define NVM_CONFIG     3'h1
`define NVM_ZERO       3'h2
`define NVM_SPAN       3'h3
`define NVM_WORDS      4'h4

// ==========================================================
// Code entry and step encodings
`define DIGIT_MAX      4'h9
`define LAST_DIGIT     2'h3
`define MAP_LAST       2'h2
`define STEP_1         4'h1
`define STEP_2         4'h2
`define STEP_5         4'h5
`define STEP_10        4'hA

// ==========================================================
// Timing
`define CLK_HZ         40000000
`define TIMEOUT_S      20
`define LEGEND_MS      1000
`define TIMEOUT_CYC    (`TIMEOUT_S * `CLK_HZ)
`define LEGEND_CYC     (`LEGEND_MS * (`CLK_HZ / 1000))

`endif

/* File: common/cmac_pkg.sv */
// Types shared by the configuration menu access controller
package cmac_pkg;

  // Controller states
  typedef enum logic [2:0] {
    st_display, st_code_prompt, st_code_entry, st_menu, st_edit,
    st_data, st_save
  } state_type;

  // Legend shown on the display
  typedef enum logic [2:0] {
    lg_process, lg_code_request, lg_code_digits, lg_item, lg_value,
    lg_data, lg_save
  } legend_type;

  // Ordered menu items
  typedef enum logic [3:0] {
    mi_mapping, mi_digit_step, mi_radix, mi_cal, mi_set, mi_pbutton,
    mi_tare, mi_code, mi_reset
  } menu_item_type;

  // Input to display mapping
  typedef enum logic [1:0] {
    map_linear, map_root, map_lineariser
  } mapping_type;

endpackage

/* File: src/settings_store.sv */
// Non-volatile settings store with registered read port
`timescale 1ns/1ps
`default_nettype none
`include "cmac_params.svh"
module settings_store (
  input  wire logic        pclk,     // Clock
  input  wire logic        presetn,  // Async reset, active low
  input  wire logic        ce,       // Clock enable
  input  wire logic        wr_en,    // Write strobe
  input  wire logic [2:0]  wr_idx,   // Write slot
  input  wire logic [15:0] wr_data,  // Write word
  input  wire logic [2:0]  rd_idx,   // Read slot
  output logic      [15:0] rd_data   // Registered read word
);

  logic [15:0] mem_q [0:7];

  // ==========================================================
  // Storage cells, factory values at reset
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_cell
      localparam logic [15:0] INIT =
        (g == `NVM_CONFIG) ? {8'h00, `DEF_TARE, `DEF_PCT, `DEF_RADIX,
                              `DEF_STEP, `DEF_MAP} :
        (g == `NVM_SPAN)   ? `DEF_SPAN :
        (g == `NVM_ZERO)   ? `DEF_ZERO : `DEF_CODE;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_q[g] <= INIT;
        end else if (ce && wr_en && wr_idx == 3'(g)) begin
          mem_q[g] <= wr_data;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Read register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 16'h0000;
    end else if (ce) begin
      rd_data <= mem_q[rd_idx];
    end
  end

endmodule
`default_nettype wire

/* File: src/config_menu_access_control.sv */
// Front-panel configuration menu entry, code check, scroll and save
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cmac_params.svh"
module config_menu_access_control
  import cmac_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `TIMEOUT_CYC,  // Inactivity limit
  parameter int LEGEND_CYCLES  = `LEGEND_CYC    // Legend hold time
) (
  input  wire logic         pclk,                // Clock, 40 MHz
  input  wire logic         presetn,             // Async reset, active low
  input  wire logic         ce,                  // Clock enable
  input  wire logic         psel,                // APB select
  input  wire logic         penable,             // APB enable
  input  wire logic         pwrite,              // APB write
  input  wire logic [7:0]   paddr,               // APB byte address
  input  wire logic [31:0]  pwdata,              // APB write data
  output logic      [31:0]  prdata,              // APB read data
  output logic              pready,              // APB ready
  output logic              pslverr,             // APB error
  input  wire logic         btn_step,            // Step button, high pressed
  input  wire logic         btn_enter,           // Enter button
  input  wire logic         btn_up,              // Up button
  input  wire logic         btn_down,            // Down button
  output legend_type        legend,              // Shown legend
  output menu_item_type     menu_item,           // Current menu item
  output logic      [1:0]   edit_digit,          // Code digit being set
  output logic      [15:0]  code_entry,          // Entered code digits
  output mapping_type       mapping_selector,    // Input mapping
  output logic      [1:0]   digit_step_setting,  // Step choice code
  output logic      [3:0]   step_counts,         // Last digit increment
  output logic      [1:0]   radix_mark_position, // 0 none, 1..3 gap
  output logic              pbutton_percent,     // Step button shows %
  output logic              tare_enable,         // Tare on
  output logic      [15:0]  zero_value,          // Display at zero input
  output logic      [15:0]  span_value,          // Display at span input
  output logic              nvm_busy             // Settings being stored
);

  state_type     state_q;
  menu_item_type item_q;
  logic [3:0]    btn_q;
  logic [3:0]    btn_now;
  logic [3:0]    press;
  logic          chord_q;
  logic          chord_rise;
  logic          any_press;
  logic [31:0]   idle_cnt_q;
  logic          timed_out;
  logic [15:0]   entry_q;
  logic [1:0]    digit_q;
  logic [15:0]   code_q;
  logic [1:0]    map_q;
  logic [1:0]    step_q;
  logic [1:0]    radix_q;
  logic          pct_q;
  logic          tare_q;
  logic [15:0]   zero_q;
  logic [15:0]   span_q;
  logic          dirty_q;
  logic [31:0]   legend_cnt_q;
  logic          legend_done;
  logic [3:0]    wr_idx_q;
  logic          wr_active;
  logic [15:0]   wr_word;
  logic [2:0]    nvm_idx_q;
  logic [15:0]   nvm_rd;
  logic [15:0]   saves_q;
  logic [31:0]   prdata_q;
  logic          bad_addr_q;
  logic          setup;
  logic          access;
  logic          apb_wr;
  logic [3:0]    cur_digit;
  logic [15:0]   config_word;
  logic          in_edit;
  logic          edit_up;
  logic          edit_down;

  // ==========================================================
  // Button edge detection
  assign btn_now    = {btn_down, btn_up, btn_enter, btn_step};
  assign press      = btn_now & ~btn_q;
  assign any_press  = |press;
  assign chord_rise = btn_step & btn_enter & ~chord_q;

  // Previous button levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_q   <= 4'h0;
      chord_q <= 1'b0;
    end else if (ce) begin
      btn_q   <= btn_now;
      chord_q <= btn_step & btn_enter;
    end
  end

  // ==========================================================
  // Inactivity timer during code request and entry
  assign timed_out = (idle_cnt_q == 32'(TIMEOUT_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_q <= 32'h0;
    end else if (ce) begin
      if (any_press || (state_q != st_code_prompt &&
                        state_q != st_code_entry)) begin
        idle_cnt_q <= 32'h0;
      end else begin
        idle_cnt_q <= idle_cnt_q + 32'h1;
      end
    end
  end

  // ==========================================================
  // Main state machine
  assign legend_done = (legend_cnt_q == 32'(LEGEND_CYCLES - 1));
  assign wr_active   = (state_q == st_save) && !wr_idx_q[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_display;
    end else if (ce) begin
      unique case (state_q)
        st_display: begin
          if (chord_rise) begin
            if (code_q == `DEF_CODE) begin
              state_q <= st_menu;
            end else begin
              state_q <= st_code_prompt;
            end
          end
        end
        st_code_prompt: begin
          if (timed_out) begin
            state_q <= st_display;
          end else if (press[0]) begin
            state_q <= st_code_entry;
          end
        end
        st_code_entry: begin
          if (timed_out) begin
            state_q <= st_display;
          end else if (press[1]) begin
            if (entry_q == code_q) begin
              state_q <= st_menu;
            end else begin
              state_q <= st_display;
            end
          end
        end
        st_menu: begin
          if (press[0]) begin
            state_q <= st_edit;
          end else if (press[1]) begin
            state_q <= dirty_q ? st_data : st_display;
          end
        end
        st_edit: begin
          if (press[1]) begin
            state_q <= st_menu;
          end
        end
        st_data: begin
          if (legend_done) begin
            state_q <= st_save;
          end
        end
        st_save: begin
          if (legend_done && wr_idx_q == `NVM_WORDS) begin
            state_q <= st_display;
          end
        end
      endcase
    end
  end

  // Legend hold counter for data and save legends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      legend_cnt_q <= 32'h0;
    end else if (ce) begin
      if ((state_q != st_data && state_q != st_save) || legend_done) begin
        legend_cnt_q <= 32'h0;
      end else begin
        legend_cnt_q <= legend_cnt_q + 32'h1;
      end
    end
  end

  // ==========================================================
  // Code entry digits
  assign cur_digit = entry_q[{digit_q, 2'b00} +: 4];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_q <= 16'h0000;
      digit_q <= 2'h0;
    end else if (ce) begin
      if (state_q != st_code_entry) begin
        entry_q <= 16'h0000;
        digit_q <= 2'h0;
      end else if (press[0]) begin
        if (digit_q != `LAST_DIGIT) begin
          digit_q <= digit_q + 2'h1;
        end
      end else if (press[2]) begin
        entry_q[{digit_q, 2'b00} +: 4] <=
          (cur_digit == `DIGIT_MAX) ? 4'h0 : cur_digit + 4'h1;
      end else if (press[3]) begin
        entry_q[{digit_q, 2'b00} +: 4] <=
          (cur_digit == 4'h0) ? `DIGIT_MAX : cur_digit - 4'h1;
      end
    end
  end

  // ==========================================================
  // Menu scrolling, wraps at both ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      item_q <= mi_mapping;
    end else if (ce) begin
      if (state_q == st_display) begin
        item_q <= mi_mapping;
      end else if (state_q == st_menu && press[2]) begin
        item_q <= (item_q == mi_reset) ? mi_mapping
                                       : menu_item_type'(item_q + 4'h1);
      end else if (state_q == st_menu && press[3]) begin
        item_q <= (item_q == mi_mapping) ? mi_reset
                                         : menu_item_type'(item_q - 4'h1);
      end
    end
  end

  // ==========================================================
  // APB slave
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign apb_wr  = ce && access && pwrite && !bad_addr_q;
  assign pready  = ce;
  assign pslverr = access && bad_addr_q;
  assign prdata  = prdata_q;

  assign config_word = {8'h00, tare_q, pct_q, radix_q, step_q, map_q};

  // Read data and decode latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q   <= 32'h0;
      bad_addr_q <= 1'b0;
    end else if (ce && setup) begin
      bad_addr_q <= 1'b0;
      unique case (paddr)
        `ADDR_STATUS:   prdata_q <= {16'h0, entry_q[15:14] & 2'h0,
                                     digit_q, item_q, 1'b0, state_q,
                                     dirty_q, wr_active, 2'h0};
        `ADDR_CODE:     prdata_q <= {16'h0, code_q};
        `ADDR_CONFIG:   prdata_q <= {16'h0, config_word};
        `ADDR_ZERO:     prdata_q <= {16'h0, zero_q};
        `ADDR_SPAN:     prdata_q <= {16'h0, span_q};
        `ADDR_NVM_IDX:  prdata_q <= {29'h0, nvm_idx_q};
        `ADDR_NVM_DATA: prdata_q <= {16'h0, nvm_rd};
        `ADDR_SAVES:    prdata_q <= {16'h0, saves_q};
        default: begin
          prdata_q   <= 32'h0;
          bad_addr_q <= 1'b1;
        end
      endcase
    end
  end

  // Stored word read index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_idx_q <= 3'h0;
    end else if (apb_wr && paddr == `ADDR_NVM_IDX) begin
      nvm_idx_q <= pwdata[2:0];
    end
  end

  // ==========================================================
  // Settings, edited by buttons or written by software
  assign in_edit   = (state_q == st_edit);
  assign edit_up   = in_edit && press[2];
  assign edit_down = in_edit && press[3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_q  <= `DEF_CODE;
      map_q   <= `DEF_MAP;
      step_q  <= `DEF_STEP;
      radix_q <= `DEF_RADIX;
      pct_q   <= `DEF_PCT;
      tare_q  <= `DEF_TARE;
      zero_q  <= `DEF_ZERO;
      span_q  <= `DEF_SPAN;
    end else if (ce) begin
      if (edit_up || edit_down) begin
        unique case (item_q)
          mi_mapping: begin
            if (edit_up) begin
              map_q <= (map_q == `MAP_LAST) ? 2'h0 : map_q + 2'h1;
            end else begin
              map_q <= (map_q == 2'h0) ? `MAP_LAST : map_q - 2'h1;
            end
          end
          mi_digit_step: begin
            step_q <= edit_up ? step_q + 2'h1 : step_q - 2'h1;
          end
          mi_radix: begin
            radix_q <= edit_up ? radix_q + 2'h1 : radix_q - 2'h1;
          end
          mi_pbutton: pct_q  <= ~pct_q;
          mi_tare:    tare_q <= ~tare_q;
          mi_reset: begin
            code_q  <= `DEF_CODE;
            map_q   <= `DEF_MAP;
            step_q  <= `DEF_STEP;
            radix_q <= `DEF_RADIX;
            pct_q   <= `DEF_PCT;
            tare_q  <= `DEF_TARE;
          end
          default: begin
          end
        endcase
      end else if (apb_wr) begin
        if (paddr == `ADDR_CODE) begin
          code_q <= pwdata[15:0];
        end
        if (paddr == `ADDR_CONFIG) begin
          map_q   <= (pwdata[`CFG_MAP_LSB +: 2] > `MAP_LAST) ? map_q
                   : pwdata[`CFG_MAP_LSB +: 2];
          step_q  <= pwdata[`CFG_STEP_LSB +: 2];
          radix_q <= pwdata[`CFG_RADIX_LSB +: 2];
          pct_q   <= pwdata[`CFG_PCT_BIT];
          tare_q  <= pwdata[`CFG_TARE_BIT];
        end
        if (paddr == `ADDR_ZERO) begin
          zero_q <= pwdata[15:0];
        end
        if (paddr == `ADDR_SPAN) begin
          span_q <= pwdata[15:0];
        end
      end
    end
  end

  // Change flag, set by any edit inside the menu
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dirty_q <= 1'b0;
    end else if (ce) begin
      if (edit_up || edit_down) begin
        dirty_q <= 1'b1;
      end else if (state_q == st_display) begin
        dirty_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Store sequence, one word a cycle under the save legend
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_idx_q <= 4'h0;
      saves_q  <= 16'h0;
    end else if (ce) begin
      if (state_q != st_save) begin
        wr_idx_q <= 4'h0;
      end else if (wr_active) begin
        wr_idx_q <= wr_idx_q + 4'h1;
        if (wr_idx_q == `NVM_WORDS - 4'h1) begin
          saves_q <= saves_q + 16'h1;
        end
      end
    end
  end

  // Word selected for the current slot
  always_comb begin
    unique case (wr_idx_q[1:0])
      2'h0:    wr_word = code_q;
      2'h1:    wr_word = config_word;
      2'h2:    wr_word = zero_q;
      default: wr_word = span_q;
    endcase
  end

  settings_store u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .wr_en   (wr_active),
    .wr_idx  (wr_idx_q[2:0]),
    .wr_data (wr_word),
    .rd_idx  (nvm_idx_q),
    .rd_data (nvm_rd)
  );

  // ==========================================================
  // Display side outputs
  always_comb begin
    unique case (state_q)
      st_code_prompt: legend = lg_code_request;
      st_code_entry:  legend = lg_code_digits;
      st_menu:        legend = lg_item;
      st_edit:        legend = lg_value;
      st_data:        legend = lg_data;
      st_save:        legend = lg_save;
      default:        legend = lg_process;
    endcase
  end

  // Increment of the least significant digit
  always_comb begin
    unique case (step_q)
      2'h0:    step_counts = `STEP_1;
      2'h1:    step_counts = `STEP_2;
      2'h2:    step_counts = `STEP_5;
      default: step_counts = `STEP_10;
    endcase
  end

  assign menu_item           = item_q;
  assign edit_digit          = digit_q;
  assign code_entry          = entry_q;
  assign mapping_selector    = mapping_type'(map_q);
  assign digit_step_setting  = step_q;
  assign radix_mark_position = radix_q;
  assign pbutton_percent     = pct_q;
  assign tare_enable         = tare_q;
  assign zero_value          = zero_q;
  assign span_value          = span_q;
  assign nvm_busy            = wr_active;

endmodule
`default_nettype wire

/* File: tb/panel_operator.sv */
// Operator model pressing the four panel buttons
`timescale 1ns/1ps
`default_nettype none
module panel_operator (
  input  wire logic pclk,      // Clock
  output logic      btn_step,  // Step
  output logic      btn_enter, // Enter
  output logic      btn_up,    // Up
  output logic      btn_down   // Down
);
  logic [3:0] b_q = 4'h0;
  // ==========================================
  // Buttons as one vector {down,up,enter,step}
  assign {btn_down, btn_up, btn_enter, btn_step} = b_q;
  // Hold a press h cycles, then release two cycles
  task automatic press(input logic [3:0] m, input int h);
    @(posedge pclk);
    b_q <= m;
    repeat (h) @(posedge pclk);
    b_q <= 4'h0;
    repeat (2) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* File: tb/cmac_asserts.sv */
// Port checks for the menu access controller
`timescale 1ns/1ps
`default_nettype none
module cmac_asserts
  import cmac_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 200  // Idle limit
) (
  input wire logic          pclk,               // Clock
  input wire logic          presetn,            // Reset
  input wire logic          btn_step,           // Step
  input wire logic          btn_enter,          // Enter
  input wire logic          btn_up,             // Up
  input wire logic          btn_down,           // Down
  input wire legend_type    legend,             // Legend
  input wire menu_item_type menu_item,          // Item
  input wire logic [1:0]    edit_digit,         // Digit
  input wire logic [1:0]    digit_step_setting, // Step code
  input wire logic [3:0]    step_counts,        // Increment
  input wire logic          nvm_busy            // Storing
);
  logic [3:0]  prev_q;
  logic [31:0] idle_q;
  logic        rise;
  logic [3:0]  up_nx;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Press detect and next item on up
  assign rise  = |({btn_down, btn_up, btn_enter, btn_step} & ~prev_q);
  assign up_nx = (menu_item == mi_reset) ? 4'h0 : menu_item + 4'h1;
  // Cycles in code request and entry since the last press
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 4'h0;
      idle_q <= 32'h0;
    end else begin
      prev_q <= {btn_down, btn_up, btn_enter, btn_step};
      if (rise || !(legend inside {lg_code_request, lg_code_digits}))
        idle_q <= 32'h0;
      else
        idle_q <= idle_q + 32'h1;
    end
  end
  // ==========================================
  // Entry, code, scroll, save and step decode steps
  sequence s_chord;
    legend == lg_process && btn_step && btn_enter
      && !$past(btn_step && btn_enter);
  endsequence
  sequence s_data_end;
    legend == lg_data ##1 legend != lg_data;
  endsequence
  a_chord_entry: assert property (s_chord |=>
    legend inside {lg_item, lg_code_request}) else $error("no entry");
  a_first_item: assert property (legend == lg_item
    && !($past(legend) inside {lg_item, lg_value})
    |-> menu_item == mi_mapping) else $error("not first item");
  a_prompt_clear: assert property (legend == lg_code_request
    && btn_step && !$past(btn_step)
    |=> legend == lg_code_digits && edit_digit == 2'h0)
    else $error("prompt kept");
  a_digit_adv: assert property (legend == lg_code_digits
    && btn_step && !$past(btn_step) && edit_digit != 2'h3
    |=> edit_digit == $past(edit_digit) + 2'h1) else $error("digit");
  a_idle_limit: assert property (
    idle_q <= TIMEOUT_CYCLES + 4) else $error("no timeout");
  a_scroll_up: assert property (legend == lg_item
    && btn_up && !$past(btn_up) |=> menu_item == $past(up_nx))
    else $error("scroll");
  a_save_order: assert property (s_data_end
    |-> legend == lg_save) else $error("no save legend");
  a_busy_len: assert property ($rose(nvm_busy)
    |-> (legend == lg_save && nvm_busy) [*4] ##1 !nvm_busy)
    else $error("store length");
  a_step_decode: assert property (step_counts ==
    (digit_step_setting == 2'h0 ? 4'h1 : digit_step_setting == 2'h1 ?
     4'h2 : digit_step_setting == 2'h2 ? 4'h5 : 4'hA))
    else $error("step decode");
endmodule
bind config_menu_access_control cmac_asserts #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) chk (.pclk, .presetn, .btn_step, .btn_enter, .btn_up, .btn_down,
  .legend, .menu_item, .edit_digit, .digit_step_setting, .step_counts,
  .nvm_busy);
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the menu access controller
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cmac_pkg::*;
;
  localparam int TO = 200;
  localparam int LG = 20;
  logic          pclk = 1'b0;
  logic          presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic          bs, be, bu, bd, busy, pct, tare, err;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rd;
  legend_type    legend;
  menu_item_type item;
  mapping_type   map;
  logic [1:0]    dig, stp, radix;
  logic [3:0]    cnt;
  logic [15:0]   code, zero, span;
  int            fails = 0;
  int            compares = 0;
  int            i;
  // Rows of {config written, increment expected}
  logic [11:0]   rows [4] = '{12'h001, 12'h152, 12'h2A5, 12'hFEA};
  always #12.5 pclk = ~pclk;
  config_menu_access_control #(.TIMEOUT_CYCLES(TO), .LEGEND_CYCLES(LG))
    uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .btn_step(bs), .btn_enter(be), .btn_up(bu),
    .btn_down(bd), .legend, .menu_item(item), .edit_digit(dig),
    .code_entry(code), .mapping_selector(map), .digit_step_setting(stp),
    .step_counts(cnt), .radix_mark_position(radix), .pbutton_percent(pct),
    .tare_enable(tare), .zero_value(zero), .span_value(span),
    .nvm_busy(busy));
  panel_operator op (.pclk, .btn_step(bs), .btn_enter(be), .btn_up(bu),
    .btn_down(bd));
  // ==========================================
  // Compare, verdict, bus and wait helpers
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic test_done;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1) begin
      fails++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_lg(input legend_type l, input int lim);
    int n;
    n = 0;
    while (legend !== l && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(legend, l);
    if (legend !== l)
      test_done();
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 8'h08, {24'h0, rows[i][11:4]});
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, {24'h0, rows[i][11:4]});
      chk({tare, pct, radix, stp, map, cnt}, rows[i]);
    end
    // Reset in mid-run restores the factory settings
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({tare, pct, radix, stp, map, cnt}, 12'h501);
    chk({zero, span}, {16'h0000, 16'h03E8});
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // Lone step is ignored, chord opens, scroll wraps both ways
    op.press(4'h1, 2);
    chk(legend, lg_process);
    op.press(4'h3, 2);
    chk({legend, item}, {lg_item, mi_mapping});
    op.press(4'h4, 2);
    chk(item, mi_digit_step);
    op.press(4'h8, 2);
    op.press(4'h8, 5);
    chk(item, mi_reset);
    op.press(4'h4, 2);
    chk(item, mi_mapping);
    op.press(4'h2, 2);
    chk(legend, lg_process);
    // Change the mapping, then leave through data and save
    op.press(4'h3, 2);
    op.press(4'h1, 2);
    op.press(4'h4, 2);
    op.press(4'h2, 2);
    chk(map, map_root);
    op.press(4'h2, 2);
    chk(legend, lg_data);
    wait_lg(lg_save, LG + 4);
    wait_lg(lg_process, LG + 4);
    apb(1'b1, 8'h14, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h51);
    apb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h1);
    // Mapping code 3 is refused, the mapping stays
    apb(1'b1, 8'h08, 32'h3);
    chk(map, map_root);
    // Stored code asks for digits, right code admits
    apb(1'b1, 8'h04, 32'h12);
    op.press(4'h3, 2);
    chk(legend, lg_code_request);
    op.press(4'h1, 2);
    chk({legend, dig}, {lg_code_digits, 2'h0});
    op.press(4'h4, 2);
    op.press(4'h4, 2);
    op.press(4'h1, 2);
    op.press(4'h4, 2);
    chk({dig, code}, {2'h1, 16'h0012});
    op.press(4'h2, 2);
    chk({legend, item}, {lg_item, mi_mapping});
    op.press(4'h2, 2);
    wait_lg(lg_process, LG * 3);
    // Wrong code goes back to display
    op.press(4'h3, 2);
    op.press(4'h1, 2);
    op.press(4'h4, 2);
    op.press(4'h2, 2);
    chk(legend, lg_process);
    // A press restarts the idle timer, silence then times out
    op.press(4'h3, 2);
    repeat (TO / 2) @(posedge pclk);
    op.press(4'h4, 2);
    repeat (TO - 50) @(posedge pclk);
    chk(legend, lg_code_request);
    wait_lg(lg_process, 60);
    test_done();
  end
endmodule
`default_nettype wire
